// File: uiem_pkg.sv
// constants for the serial peripheral interrupt enable mask
// Notes on behaviour
// R01: writing 1 to the clear-to-send bit of the set view enables it; reads show state
// R02: writing 1 to the clear-to-send-deasserted bit of the set view enables it
// R03: writing 1 to the receive-byte-ready bit of the set view enables it
// R04: writing 1 to the transmit-byte-sent bit of the set view enables it
// R05: writing 1 to the error bit of the set view enables it; reads 1 or 0
// R06: writing 1 to the receiver-timeout bit of the set view enables it
// R07: writing 1 to the clear-to-send bit of the clear view disables it; reads show state
// R08: writing 1 to the clear-to-send-deasserted bit of the clear view disables it
// R09: writing 1 to the receive-byte-ready bit of the clear view disables it
// R10: clear view also disables transmit-sent, error and timeout; reads show shared state
// R11: one shared bit per event; writing 0 changes nothing; reset disables all
// R12: interrupt request is high while any flagged event is also enabled
`default_nettype none
package uiem_pkg;
  localparam int unsigned N_EVENTS = 6;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_SET   = 12'h304;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_CLEAR = 12'h308;
  localparam logic [5:0]  ENABLE_RESET               = 6'h00;
  localparam logic [1:0]  HTRANS_NONSEQ_BIT          = 2'h2;
  localparam logic        HRESP_OKAY                 = 1'b0;
  // word bit of each event: clear_to_send, clear_to_send_deasserted,
  // receive_byte_ready, transmit_byte_sent, error, receiver_timeout
  localparam int unsigned POS_CLEAR_TO_SEND            = 0;
  localparam int unsigned POS_CLEAR_TO_SEND_DEASSERTED = 1;
  localparam int unsigned POS_RECEIVE_BYTE_READY       = 2;
  localparam int unsigned POS_TRANSMIT_BYTE_SENT       = 7;
  localparam int unsigned POS_ERROR                    = 9;
  localparam int unsigned POS_RECEIVER_TIMEOUT         = 17;
  localparam int unsigned EVENT_POS [0:N_EVENTS-1] = '{POS_CLEAR_TO_SEND, POS_CLEAR_TO_SEND_DEASSERTED,
                                                       POS_RECEIVE_BYTE_READY, POS_TRANSMIT_BYTE_SENT,
                                                       POS_ERROR, POS_RECEIVER_TIMEOUT};
endpackage
`default_nettype wire

// File: uiem_top.sv
// interrupt enable mask with set and clear views on an ahb-lite slave
`timescale 1ns/1ns
`default_nettype none
module uiem_top
  import uiem_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [5:0]  event_flags,
  output logic [5:0]       enable_mask,
  output logic             irq
);

  logic        dp_write;
  logic        dp_set;
  logic        dp_clr;
  logic [5:0]  enable;
  logic [5:0]  next_enable;
  logic [5:0]  wr_bits;
  logic        ap_take;
  logic        ap_mapped;
  logic [31:0] next_rdata;

  // spread the six enables onto their word bits
  function automatic logic [31:0] spread(input logic [5:0] v);
    logic [31:0] w;
    w = 32'h00000000;
    for (int i = 0; i < N_EVENTS; i++) begin
      w[EVENT_POS[i]] = v[i];
    end
    return w;
  endfunction

  // gather the six fields from a written word
  function automatic logic [5:0] gather(input logic [31:0] w);
    logic [5:0] v;
    v = 6'h00;
    for (int i = 0; i < N_EVENTS; i++) begin
      v[i] = w[EVENT_POS[i]];
    end
    return v;
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign ap_take   = hsel && hready && ((htrans & HTRANS_NONSEQ_BIT) != 2'h0);
  assign ap_mapped = (haddr[11:0] == OFF_INTERRUPT_ENABLE_SET) || (haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR);

  // address phase capture of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_set   <= 1'b0;
      dp_clr   <= 1'b0;
    end else if (hready) begin
      dp_write <= ap_take && hwrite;
      dp_set   <= ap_take && hwrite && (haddr[11:0] == OFF_INTERRUPT_ENABLE_SET);
      dp_clr   <= ap_take && hwrite && (haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR);
    end
  end

  assign wr_bits = gather(hwdata);

  // shared enable bits, set view ors in, clear view masks out
  always_comb begin
    next_enable = enable;
    if (dp_set) begin
      next_enable = enable | wr_bits; // R01 R02 R03 R04 R05 R06 R11
    end else if (dp_clr) begin
      next_enable = enable & ~wr_bits; // R07 R08 R09 R10 R11
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable <= ENABLE_RESET; // R11
    end else begin
      enable <= next_enable;
    end
  end

  // both views read the same mask, unmapped reads give zero
  assign next_rdata = (ap_take && !hwrite && ap_mapped) ? spread(next_enable) : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready) begin
      hrdata <= next_rdata; // R01 R05 R07 R08 R09 R10
    end
  end

  assign enable_mask = enable;
  assign irq         = |(event_flags & enable); // R12

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_set_view_ors: assert property (dp_set |=> enable == ($past(enable) | $past(wr_bits))) // R01
    else $error("set view write did not or in the written ones");
  a_set_view_keep: assert property (dp_set |=> (enable & $past(enable)) == $past(enable)) // R06
    else $error("set view write dropped an enable");
  a_clear_view_masks: assert property (dp_clr |=> enable == ($past(enable) & ~$past(wr_bits))) // R07
    else $error("clear view write did not mask the written ones");
  a_clear_view_keep: assert property (dp_clr |=> (enable | $past(enable)) == $past(enable)) // R10
    else $error("clear view write raised an enable");
  a_idle_holds: assert property (!dp_set && !dp_clr |=> $stable(enable)) // R11
    else $error("enable changed without a write");
  a_read_shows_mask: assert property (ap_take && !hwrite && ap_mapped ##1 !dp_write // R08
                                      |-> hrdata == spread(enable))
    else $error("read view does not match the shared mask");
  a_read_unmapped_zero: assert property (ap_take && !hwrite && !ap_mapped |=> hrdata == 32'h00000000) // R09
    else $error("unmapped read not zero");
  a_irq_gated: assert property (irq == ((event_flags & enable_mask) != 6'h00)) // R12
    else $error("interrupt request disagrees with flags and mask");
  a_error_field_set: assert property (dp_set && hwdata[POS_ERROR] |=> enable[4]) // R05
    else $error("error enable not set");
  a_ready_okay: assert property (hreadyout && hresp == HRESP_OKAY) // R03
    else $error("slave not ready or not okay");

  // clear-to-send enable bit
  a_cts_set_on: assert property ( // R01
    dp_set && wr_bits[0]
    |=> enable[0])
    else $error("clear-to-send enable not set by a set view write");
  a_cts_clr_off: assert property ( // R07
    dp_clr && wr_bits[0]
    |=> !enable[0])
    else $error("clear-to-send enable not cleared by a clear view write");
  a_cts_set_hold: assert property ( // R11
    dp_set && !wr_bits[0]
    |=> $stable(enable[0]))
    else $error("clear-to-send enable moved on a zero set view write");
  a_cts_clr_hold: assert property ( // R11
    dp_clr && !wr_bits[0]
    |=> $stable(enable[0]))
    else $error("clear-to-send enable moved on a zero clear view write");
  a_cts_set_read: assert property ( // R01
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_SET
    |=> hrdata[POS_CLEAR_TO_SEND] == enable[0])
    else $error("clear-to-send field misread through the set view");
  a_cts_clr_read: assert property ( // R07
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR
    |=> hrdata[POS_CLEAR_TO_SEND] == enable[0])
    else $error("clear-to-send field misread through the clear view");
  a_cts_irq_on: assert property ( // R12
    event_flags[0] && enable[0]
    |-> irq)
    else $error("clear-to-send event enabled but no interrupt request");
  a_cts_irq_masked: assert property ( // R12
    event_flags == 6'h01 && !enable[0]
    |-> !irq)
    else $error("clear-to-send event masked but interrupt request high");

  // clear-to-send-deasserted enable bit
  a_ctsoff_set_on: assert property ( // R02
    dp_set && wr_bits[1]
    |=> enable[1])
    else $error("clear-to-send-deasserted enable not set by a set view write");
  a_ctsoff_clr_off: assert property ( // R08
    dp_clr && wr_bits[1]
    |=> !enable[1])
    else $error("clear-to-send-deasserted enable not cleared by a clear view write");
  a_ctsoff_set_hold: assert property ( // R11
    dp_set && !wr_bits[1]
    |=> $stable(enable[1]))
    else $error("clear-to-send-deasserted enable moved on a zero set view write");
  a_ctsoff_clr_hold: assert property ( // R11
    dp_clr && !wr_bits[1]
    |=> $stable(enable[1]))
    else $error("clear-to-send-deasserted enable moved on a zero clear view write");
  a_ctsoff_set_read: assert property ( // R02
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_SET
    |=> hrdata[POS_CLEAR_TO_SEND_DEASSERTED] == enable[1])
    else $error("clear-to-send-deasserted field misread through the set view");
  a_ctsoff_clr_read: assert property ( // R08
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR
    |=> hrdata[POS_CLEAR_TO_SEND_DEASSERTED] == enable[1])
    else $error("clear-to-send-deasserted field misread through the clear view");
  a_ctsoff_irq_on: assert property ( // R12
    event_flags[1] && enable[1]
    |-> irq)
    else $error("clear-to-send-deasserted event enabled but no interrupt request");
  a_ctsoff_irq_masked: assert property ( // R12
    event_flags == 6'h02 && !enable[1]
    |-> !irq)
    else $error("clear-to-send-deasserted event masked but interrupt request high");

  // receive-byte-ready enable bit
  a_rxbyte_set_on: assert property ( // R03
    dp_set && wr_bits[2]
    |=> enable[2])
    else $error("receive-byte-ready enable not set by a set view write");
  a_rxbyte_clr_off: assert property ( // R09
    dp_clr && wr_bits[2]
    |=> !enable[2])
    else $error("receive-byte-ready enable not cleared by a clear view write");
  a_rxbyte_set_hold: assert property ( // R11
    dp_set && !wr_bits[2]
    |=> $stable(enable[2]))
    else $error("receive-byte-ready enable moved on a zero set view write");
  a_rxbyte_clr_hold: assert property ( // R11
    dp_clr && !wr_bits[2]
    |=> $stable(enable[2]))
    else $error("receive-byte-ready enable moved on a zero clear view write");
  a_rxbyte_set_read: assert property ( // R03
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_SET
    |=> hrdata[POS_RECEIVE_BYTE_READY] == enable[2])
    else $error("receive-byte-ready field misread through the set view");
  a_rxbyte_clr_read: assert property ( // R09
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR
    |=> hrdata[POS_RECEIVE_BYTE_READY] == enable[2])
    else $error("receive-byte-ready field misread through the clear view");
  a_rxbyte_irq_on: assert property ( // R12
    event_flags[2] && enable[2]
    |-> irq)
    else $error("receive-byte-ready event enabled but no interrupt request");
  a_rxbyte_irq_masked: assert property ( // R12
    event_flags == 6'h04 && !enable[2]
    |-> !irq)
    else $error("receive-byte-ready event masked but interrupt request high");

  // transmit-byte-sent enable bit
  a_txdone_set_on: assert property ( // R04
    dp_set && wr_bits[3]
    |=> enable[3])
    else $error("transmit-byte-sent enable not set by a set view write");
  a_txdone_clr_off: assert property ( // R10
    dp_clr && wr_bits[3]
    |=> !enable[3])
    else $error("transmit-byte-sent enable not cleared by a clear view write");
  a_txdone_set_hold: assert property ( // R11
    dp_set && !wr_bits[3]
    |=> $stable(enable[3]))
    else $error("transmit-byte-sent enable moved on a zero set view write");
  a_txdone_clr_hold: assert property ( // R11
    dp_clr && !wr_bits[3]
    |=> $stable(enable[3]))
    else $error("transmit-byte-sent enable moved on a zero clear view write");
  a_txdone_set_read: assert property ( // R04
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_SET
    |=> hrdata[POS_TRANSMIT_BYTE_SENT] == enable[3])
    else $error("transmit-byte-sent field misread through the set view");
  a_txdone_clr_read: assert property ( // R10
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR
    |=> hrdata[POS_TRANSMIT_BYTE_SENT] == enable[3])
    else $error("transmit-byte-sent field misread through the clear view");
  a_txdone_irq_on: assert property ( // R12
    event_flags[3] && enable[3]
    |-> irq)
    else $error("transmit-byte-sent event enabled but no interrupt request");
  a_txdone_irq_masked: assert property ( // R12
    event_flags == 6'h08 && !enable[3]
    |-> !irq)
    else $error("transmit-byte-sent event masked but interrupt request high");

  // error enable bit
  a_error_set_on: assert property ( // R05
    dp_set && wr_bits[4]
    |=> enable[4])
    else $error("error enable not set by a set view write");
  a_error_clr_off: assert property ( // R10
    dp_clr && wr_bits[4]
    |=> !enable[4])
    else $error("error enable not cleared by a clear view write");
  a_error_set_hold: assert property ( // R11
    dp_set && !wr_bits[4]
    |=> $stable(enable[4]))
    else $error("error enable moved on a zero set view write");
  a_error_clr_hold: assert property ( // R11
    dp_clr && !wr_bits[4]
    |=> $stable(enable[4]))
    else $error("error enable moved on a zero clear view write");
  a_error_set_read: assert property ( // R05
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_SET
    |=> hrdata[POS_ERROR] == enable[4])
    else $error("error field misread through the set view");
  a_error_clr_read: assert property ( // R10
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR
    |=> hrdata[POS_ERROR] == enable[4])
    else $error("error field misread through the clear view");
  a_error_irq_on: assert property ( // R12
    event_flags[4] && enable[4]
    |-> irq)
    else $error("error event enabled but no interrupt request");
  a_error_irq_masked: assert property ( // R12
    event_flags == 6'h10 && !enable[4]
    |-> !irq)
    else $error("error event masked but interrupt request high");

  // receiver-timeout enable bit
  a_rxtimeout_set_on: assert property ( // R06
    dp_set && wr_bits[5]
    |=> enable[5])
    else $error("receiver-timeout enable not set by a set view write");
  a_rxtimeout_clr_off: assert property ( // R10
    dp_clr && wr_bits[5]
    |=> !enable[5])
    else $error("receiver-timeout enable not cleared by a clear view write");
  a_rxtimeout_set_hold: assert property ( // R11
    dp_set && !wr_bits[5]
    |=> $stable(enable[5]))
    else $error("receiver-timeout enable moved on a zero set view write");
  a_rxtimeout_clr_hold: assert property ( // R11
    dp_clr && !wr_bits[5]
    |=> $stable(enable[5]))
    else $error("receiver-timeout enable moved on a zero clear view write");
  a_rxtimeout_set_read: assert property ( // R06
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_SET
    |=> hrdata[POS_RECEIVER_TIMEOUT] == enable[5])
    else $error("receiver-timeout field misread through the set view");
  a_rxtimeout_clr_read: assert property ( // R10
    ap_take && !hwrite && haddr[11:0] == OFF_INTERRUPT_ENABLE_CLEAR
    |=> hrdata[POS_RECEIVER_TIMEOUT] == enable[5])
    else $error("receiver-timeout field misread through the clear view");
  a_rxtimeout_irq_on: assert property ( // R12
    event_flags[5] && enable[5]
    |-> irq)
    else $error("receiver-timeout event enabled but no interrupt request");
  a_rxtimeout_irq_masked: assert property ( // R12
    event_flags == 6'h20 && !enable[5]
    |-> !irq)
    else $error("receiver-timeout event masked but interrupt request high");

  // reset and shared checks
  a_reset_clears: assert property ( // R11
    @(posedge hclk) disable iff (1'b0) !hresetn
    |=> enable == ENABLE_RESET && hrdata == 32'h00000000)
    else $error("reset left an enable or read data set");
  a_views_exclusive: assert property ( // R11
    dp_set
    |-> !dp_clr)
    else $error("set and clear views acted in one cycle");
  a_unused_bits_zero: assert property ( // R10
    ap_take && !hwrite
    |=> (hrdata & ~spread(6'h3F)) == 32'h00000000)
    else $error("read data shows a bit outside the six fields");
  a_irq_quiet: assert property ( // R12
    (event_flags & enable) == 6'h00
    |-> !irq)
    else $error("interrupt request high with no enabled event");

endmodule
`default_nettype wire

// File: uiem_tb.sv
// self-checking bench for the interrupt enable mask
`timescale 1ns/1ns
`default_nettype none
module testbench
  import uiem_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0]  event_flags = 6'h0;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [5:0]  enable_mask;
  logic        irq;
  logic [31:0] r;
  logic [31:0] p;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  localparam logic [31:0] SET = {20'h0, OFF_INTERRUPT_ENABLE_SET};
  localparam logic [31:0] CLR = {20'h0, OFF_INTERRUPT_ENABLE_CLEAR};
  always #20 hclk = ~hclk;
  uiem_top i_uiem_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .event_flags(event_flags), .enable_mask(enable_mask), .irq(irq));
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(SET, 1'h0, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    for (int i = 0; i < N_EVENTS; i++) begin
      p = 32'h1 << EVENT_POS[i];
      xfer(SET, 1'h1, p, r);
      xfer(CLR, 1'h0, 32'h0, r);
      chk(r, p);
      event_flags <= 6'h3F ^ (6'h1 << i);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      event_flags <= 6'h1 << i;
      @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      chk({26'h0, enable_mask}, 32'h1 << i);
      xfer(CLR, 1'h1, p, r);
      xfer(SET, 1'h0, 32'h0, r);
      chk(r, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    p = 32'h0;
    for (int i = 0; i < N_EVENTS; i++) begin
      p = p | (32'h1 << EVENT_POS[i]);
    end
    xfer(SET, 1'h1, 32'hFFFFFFFF, r);
    xfer(CLR, 1'h1, 32'h0, r);
    xfer(SET, 1'h1, 32'h0, r);
    xfer(SET, 1'h0, 32'h0, r);
    chk(r, p);
    chk({31'h0, irq}, 32'h1);
    xfer(32'h300, 1'h1, 32'hFFFFFFFF, r);
    xfer(32'h300, 1'h0, 32'h0, r);
    chk(r, 32'h0);
    xfer(CLR, 1'h0, 32'h0, r);
    chk(r, p);
    xfer(CLR, 1'h1, p & ~32'h1, r);
    xfer(CLR, 1'h0, 32'h0, r);
    chk(r, 32'h1);
    chk({31'h0, irq}, 32'h0);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    xfer(CLR, 1'h0, 32'h0, r);
    chk(r, 32'h0);
    chk({26'h0, enable_mask}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
